// ===== verification/serial_peer.sv
// Far-end serial transmitter model that drives the receive line.
`timescale 1ns/1ps
module serial_peer (
   input wire logic pclk,
   input wire logic start_req,
   output logic rx_line
);
   int hold = 0;
   logic line_low = 1'b0;
   // The line idles high between frames; a start request pulls it low for a start bit.
   always @(posedge pclk) begin
      hold <= start_req ? 8 : (hold > 0 ? hold - 1 : 0);
      line_low <= start_req || hold > 1;
   end
   // One driver only, so the line shows its idle high level from time zero.
   assign rx_line = !line_low;
endmodule : serial_peer

// ===== verification/testbench.sv
// Self-checking bench for the serial control block.
`timescale 1ns/1ps
module testbench;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, q;
   logic fh_running = 1'b1, rx_word_valid = 1'b0, start_req = 1'b0, rx_pin, acc, qerr;
   logic tx_busy = 1'b0, tx_serial = 1'b1, tx_pin_out, tx_pin_oe, rx_pin_owned;
   wire [5:0] fmt;
   logic [8:0] rx_word = 9'h000;
   logic [4:0] pulses = 5'h00;
   logic [31:0] prdata;
   logic pready, pslverr, baud_tick, rx_word_accept, datapath_flush, wake_request, uart_irq;
   int errors = 0, tests_run = 0, n;
   always #12.5 pclk = ~pclk;
   serial_peer i_serial_peer (.pclk(pclk), .start_req(start_req), .rx_line(rx_pin));
   uart_ctl i_uart_ctl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
      .fh_running(fh_running), .rx_word_valid(rx_word_valid), .rx_word(rx_word), .rx_ready_clear(1'b0),
      .overrun_set(pulses[4]), .framing_set(pulses[3]), .parity_set(pulses[2]), .noise_set(pulses[1]),
      .tx_empty_set(1'b0), .tx_empty_clear(pulses[0]), .tx_busy(tx_busy), .tx_serial(tx_serial), .rx_busy(1'b0),
      .baud_tick(baud_tick), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .rx_pin_owned(rx_pin_owned),
      .rx_word_accept(rx_word_accept), .datapath_flush(datapath_flush), .nine_bit_select(fmt[5]),
      .parity_on(fmt[4]), .parity_odd_select(fmt[3]), .two_stop_select(fmt[2]), .break_send(fmt[1]),
      .tx_ninth_bit(fmt[0]), .wake_request(wake_request), .uart_irq(uart_irq));
   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // One APB transfer; the request is held until pready is seen high at an edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      // A slave that never answers ends the run through the closing report.
      if (pready !== 1'b1) begin
         chk(n, 0);
         give_verdict();
      end
      q = prdata;
      qerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // Counts edges until a flag is seen high, bounded so a hang counts as a mismatch.
   task automatic wait_hi(ref logic s, input int lim);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (s !== 1'b1 && n < lim);
      if (s !== 1'b1) begin
         chk(s, 1'b1);
         give_verdict();
      end
   endtask : wait_hi
   task automatic send_word(input logic [8:0] w);
      rx_word <= w;
      rx_word_valid <= 1'b1;
      @(posedge pclk);
      rx_word_valid <= 1'b0;
      acc = 1'b0;
      repeat (3) begin
         @(posedge pclk);
         acc = acc | rx_word_accept;
      end
   endtask : send_word
   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_regs;
      apb(0, uart_ctl_pkg::ADDR_CONTROL_A, 0);
      chk(q, 32'h00);
      chk(fmt, 6'h00);
      apb(0, uart_ctl_pkg::ADDR_CONTROL_B, 0);
      chk(q, 32'h00);
      apb(0, 8'h10, 0);
      chk(q, 32'h00);
      chk(qerr, 1'b1);
      $display("done regs");
   endtask : t_regs
   task automatic t_baud;
      apb(1, uart_ctl_pkg::ADDR_DIVISOR, 32'h01);
      apb(1, uart_ctl_pkg::ADDR_CONTROL_B, 32'h20);
      apb(1, uart_ctl_pkg::ADDR_CONTROL_A, 32'h80);
      wait_hi(baud_tick, 200);
      wait_hi(baud_tick, 200);
      chk(n, 32);
      $display("done baud");
   endtask : t_baud
   task automatic t_addr;
      apb(1, uart_ctl_pkg::ADDR_CONTROL_B, 32'h54);
      send_word(9'h005);
      chk({acc, uart_irq}, 2'b00);
      send_word(9'h085);
      chk({acc, uart_irq}, 2'b11);
      $display("done address");
   endtask : t_addr
   task automatic t_wake;
      apb(1, uart_ctl_pkg::ADDR_CONTROL_B, 32'h0C);
      start_req <= 1'b1;
      @(posedge pclk);
      start_req <= 1'b0;
      repeat (12) @(posedge pclk);
      chk(wake_request, 1'b0);
      fh_running <= 1'b0;
      repeat (4) @(posedge pclk);
      start_req <= 1'b1;
      @(posedge pclk);
      start_req <= 1'b0;
      wait_hi(wake_request, 12);
      chk(wake_request, 1'b1);
      $display("done wake");
   endtask : t_wake
   task automatic t_disable;
      apb(1, uart_ctl_pkg::ADDR_CONTROL_A, 32'h84);
      apb(1, uart_ctl_pkg::ADDR_CONTROL_B, 32'hCC);
      pulses <= 5'h1F;
      @(posedge pclk);
      pulses <= 5'h00;
      apb(0, uart_ctl_pkg::ADDR_STATUS, 0);
      // Ready is left from the address test; idle survives the load because a set beats a clear.
      chk(q & 32'h7F, 32'h3F);
      chk(fmt, 6'h02);
      apb(1, uart_ctl_pkg::ADDR_CONTROL_A, 32'h00);
      apb(0, uart_ctl_pkg::ADDR_STATUS, 0);
      chk(q & 32'hFF, 32'hE0);
      chk(fmt, 6'h00);
      apb(0, uart_ctl_pkg::ADDR_CONTROL_B, 0);
      chk(q, 32'h0C);
      apb(0, uart_ctl_pkg::ADDR_DIVISOR, 0);
      chk(q, 32'h01);
      chk(datapath_flush, 1'b1);
      $display("done disable");
   endtask : t_disable
   // Re-enable: pin ownership, idle level, retained divisor at low speed, transmit interrupts.
   task automatic t_pins;
      apb(1, uart_ctl_pkg::ADDR_CONTROL_B, 32'hC0);
      apb(1, uart_ctl_pkg::ADDR_CONTROL_A, 32'h80);
      @(posedge pclk);
      chk({tx_pin_oe, rx_pin_owned, tx_pin_out, uart_irq}, 4'hE);
      tx_busy <= 1'b1;
      tx_serial <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(tx_pin_out, 1'b0);
      tx_busy <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(tx_pin_out, 1'b1);
      wait_hi(baud_tick, 200);
      wait_hi(baud_tick, 200);
      chk(n, 128);
      apb(1, uart_ctl_pkg::ADDR_CONTROL_B, 32'hC2);
      @(posedge pclk);
      chk(uart_irq, 1'b1);
      apb(1, uart_ctl_pkg::ADDR_CONTROL_B, 32'hC1);
      @(posedge pclk);
      chk(uart_irq, 1'b1);
      $display("done pins");
   endtask : t_pins
   task automatic give_verdict;
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : give_verdict
   // Main sequence: reset for six cycles, then each scenario in turn.
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_baud();
      t_addr();
      t_wake();
      t_disable();
      t_pins();
      give_verdict();
   end
endmodule : testbench

// ===== verilog/baud_timer.sv
// Baud rate generator: prescaler plus reloading 8-bit timer.
`timescale 1ns/1ps
module baud_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic high_speed,
   input wire logic [7:0] divisor,
   output logic bit_tick
);
   logic [5:0] pre_count;
   logic [7:0] timer;
   wire logic [5:0] pre_last;
   wire logic pre_tick;
   wire logic timer_wrap;

   // -------------------------------------------------------------------------
   // Prescale selection
   // -------------------------------------------------------------------------
   // Divide by 16 in high speed, else by 64.
   assign pre_last = high_speed ? uart_ctl_pkg::PRESCALE_HIGH_LAST
                                : uart_ctl_pkg::PRESCALE_LOW_LAST;
   assign pre_tick = (pre_count == pre_last);
   assign timer_wrap = pre_tick && (timer == divisor);

   // Both counters restart while stopped, so the first bit after enable is full length.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_count <= 6'h00;
         timer <= 8'h00;
         bit_tick <= 1'b0;
      end else if (!run) begin
         pre_count <= 6'h00;
         timer <= 8'h00;
         bit_tick <= 1'b0;
      end else begin
         pre_count <= pre_tick ? 6'h00 : pre_count + 6'h01;
         if (pre_tick) begin
            timer <= timer_wrap ? 8'h00 : timer + 8'h01;
         end
         bit_tick <= timer_wrap;
      end
   end
endmodule : baud_timer

// ===== verilog/uart_ctl.sv
// Serial transceiver control: registers, baud, address filter, wake and interrupt.
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module uart_ctl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_pin,
   input wire logic fh_running,
   input wire logic rx_word_valid,
   input wire logic [8:0] rx_word,
   input wire logic rx_ready_clear,
   input wire logic overrun_set,
   input wire logic framing_set,
   input wire logic parity_set,
   input wire logic noise_set,
   input wire logic tx_empty_set,
   input wire logic tx_empty_clear,
   input wire logic tx_busy,
   input wire logic tx_serial,
   input wire logic rx_busy,
   output logic baud_tick,
   output logic tx_pin_out,
   output logic tx_pin_oe,
   output logic rx_pin_owned,
   output logic rx_word_accept,
   output logic datapath_flush,
   output logic nine_bit_select,
   output logic parity_on,
   output logic parity_odd_select,
   output logic two_stop_select,
   output logic break_send,
   output logic tx_ninth_bit,
   output logic wake_request,
   output logic uart_irq
);
   // -------------------------------------------------------------------------
   // Storage
   // -------------------------------------------------------------------------
   logic [7:0] uart_control_a;
   logic [7:0] uart_control_b;
   logic [7:0] baud_divisor_reg;
   logic rx_data_ready, overrun_error, framing_error, parity_error, noise_flag;
   logic tx_idle_flag, tx_buffer_empty, rx_quiet_flag, addr_hit;
   logic rx_meta, rx_sync, rx_prev, fh_meta, fh_sync;

   // -------------------------------------------------------------------------
   // Bus decode
   // -------------------------------------------------------------------------
   // Decode happens in the setup cycle; data is committed at the access edge.
   wire logic bus_setup = psel && !penable;
   wire logic bus_access = psel && penable && pready;
   wire logic hit_a = (paddr == uart_ctl_pkg::ADDR_CONTROL_A);
   wire logic hit_b = (paddr == uart_ctl_pkg::ADDR_CONTROL_B);
   wire logic hit_div = (paddr == uart_ctl_pkg::ADDR_DIVISOR);
   wire logic hit_stat = (paddr == uart_ctl_pkg::ADDR_STATUS);
   wire logic mapped = hit_a || hit_b || hit_div || hit_stat;
   wire logic wr_a = bus_access && pwrite && hit_a;
   wire logic wr_b = bus_access && pwrite && hit_b;
   wire logic wr_div = bus_access && pwrite && hit_div;
   wire logic wr_stat = bus_access && pwrite && hit_stat;
   wire logic master = uart_control_a[uart_ctl_pkg::A_MASTER];
   // A write that leaves the master bit low shuts the block down.
   wire logic shut = wr_a && !pwdata[uart_ctl_pkg::A_MASTER];
   wire logic active = master && !shut;

   // -------------------------------------------------------------------------
   // Status word
   // -------------------------------------------------------------------------
   wire logic [9:0] status_word = {wake_request, addr_hit, rx_quiet_flag, tx_buffer_empty,
                                   tx_idle_flag, noise_flag, parity_error, framing_error,
                                   overrun_error, rx_data_ready};
   wire logic [31:0] read_mux = hit_a ? {24'h000000, uart_control_a} :
                                hit_b ? {24'h000000, uart_control_b} :
                                hit_div ? {24'h000000, baud_divisor_reg} :
                                hit_stat ? {22'h000000, status_word} : 32'h00000000;

   // Zero-wait slave: ready and read data are loaded during the setup cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= bus_setup;
         pslverr <= bus_setup && !mapped;
         prdata <= (bus_setup && !pwrite) ? read_mux : 32'h00000000;
      end
   end

   // -------------------------------------------------------------------------
   // Control registers
   // -------------------------------------------------------------------------
   // On shutdown the transmitter, receiver and break bits drop; the rest of control B stays, control A takes the written value except the received ninth bit.
   wire logic [7:0] next_control_a = {pwdata[7:3], pwdata[uart_ctl_pkg::A_BREAK] && pwdata[uart_ctl_pkg::A_MASTER],
                                      uart_control_a[uart_ctl_pkg::A_RX_NINTH], pwdata[uart_ctl_pkg::A_TX_NINTH]};
   wire logic rx_word_accept_c;
   wire logic addr_bit = nine_bit_select ? rx_word[8] : rx_word[7];
   wire logic addr_det = uart_control_b[uart_ctl_pkg::B_ADDR_DET];
   assign rx_word_accept_c = !addr_det || addr_bit;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uart_control_a <= uart_ctl_pkg::RESET_CONTROL_A;
      end else if (wr_a) begin
         uart_control_a <= next_control_a;
      end else if (rx_word_valid && rx_word_accept_c && master) begin
         uart_control_a[uart_ctl_pkg::A_RX_NINTH] <= rx_word[8];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uart_control_b <= uart_ctl_pkg::RESET_CONTROL_B;
      end else if (wr_b) begin
         uart_control_b <= pwdata[7:0];
      end else if (shut) begin
         uart_control_b[uart_ctl_pkg::B_TX_ON] <= 1'b0;
         uart_control_b[uart_ctl_pkg::B_RX_ON] <= 1'b0;
      end
   end

   // Divisor survives disable so a re-enable runs at the same rate.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         baud_divisor_reg <= uart_ctl_pkg::RESET_DIVISOR;
      end else if (wr_div) begin
         baud_divisor_reg <= pwdata[7:0];
      end
   end

   // -------------------------------------------------------------------------
   // Baud generator
   // -------------------------------------------------------------------------
   // One tick serves both directions, so they always share the bit rate.
   baud_timer u_baud (
      .pclk(pclk),
      .presetn(presetn),
      .run(master),
      .high_speed(uart_control_b[uart_ctl_pkg::B_SPEED]),
      .divisor(baud_divisor_reg),
      .bit_tick(baud_tick)
   );

   // -------------------------------------------------------------------------
   // Format outputs and pin ownership
   // -------------------------------------------------------------------------
   wire logic tx_own = active && uart_control_b[uart_ctl_pkg::B_TX_ON];
   wire logic rx_own = active && uart_control_b[uart_ctl_pkg::B_RX_ON];

   // Format bits are registered copies so the datapath sees one settled frame shape.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nine_bit_select <= 1'b0;
         parity_on <= 1'b0;
         parity_odd_select <= 1'b0;
         two_stop_select <= 1'b0;
         break_send <= 1'b0;
         tx_ninth_bit <= 1'b0;
         tx_pin_oe <= 1'b0;
         tx_pin_out <= 1'b1;
         rx_pin_owned <= 1'b0;
         datapath_flush <= 1'b1;
      end else begin
         nine_bit_select <= uart_control_a[uart_ctl_pkg::A_NINE_BIT];
         parity_on <= uart_control_a[uart_ctl_pkg::A_PARITY_ON];
         parity_odd_select <= uart_control_a[uart_ctl_pkg::A_PARITY_ODD];
         two_stop_select <= uart_control_a[uart_ctl_pkg::A_TWO_STOP];
         break_send <= uart_control_a[uart_ctl_pkg::A_BREAK] && active;
         tx_ninth_bit <= uart_control_a[uart_ctl_pkg::A_TX_NINTH];
         tx_pin_oe <= tx_own;
         tx_pin_out <= (tx_busy && tx_own) ? tx_serial : 1'b1;
         rx_pin_owned <= rx_own;
         datapath_flush <= !active;
      end
   end

   // -------------------------------------------------------------------------
   // Address filter
   // -------------------------------------------------------------------------
   // Rejected words never reach the ready flag, so they raise nothing.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_word_accept <= 1'b0;
      end else begin
         rx_word_accept <= rx_word_valid && rx_own && rx_word_accept_c;
      end
   end

   // -------------------------------------------------------------------------
   // Flags
   // -------------------------------------------------------------------------
   wire logic rx_take = rx_word_valid && rx_own && rx_word_accept_c;
   wire logic addr_take = rx_take && addr_det && addr_bit;
   wire logic idle_cond = tx_buffer_empty && !tx_busy;
   // Hardware sets beat clears arriving in the same cycle, except a disable, which returns every flag but the wake request to its reset value.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_data_ready <= 1'b0;
         overrun_error <= 1'b0;
         framing_error <= 1'b0;
         parity_error <= 1'b0;
         noise_flag <= 1'b0;
         tx_buffer_empty <= 1'b1;
         tx_idle_flag <= 1'b1;
         rx_quiet_flag <= 1'b1;
         addr_hit <= 1'b0;
      end else if (!active) begin
         rx_data_ready <= 1'b0;
         overrun_error <= 1'b0;
         framing_error <= 1'b0;
         parity_error <= 1'b0;
         noise_flag <= 1'b0;
         tx_buffer_empty <= 1'b1;
         tx_idle_flag <= 1'b1;
         rx_quiet_flag <= 1'b1;
         addr_hit <= 1'b0;
      end else begin
         rx_data_ready <= rx_take || (rx_data_ready && !rx_ready_clear);
         overrun_error <= overrun_set || (overrun_error && !rx_ready_clear);
         framing_error <= framing_set || (framing_error && !rx_ready_clear);
         parity_error <= parity_set || (parity_error && !rx_ready_clear);
         noise_flag <= noise_set || (noise_flag && !rx_ready_clear);
         tx_buffer_empty <= tx_empty_set || (tx_buffer_empty && !tx_empty_clear);
         tx_idle_flag <= idle_cond || (tx_idle_flag && !tx_empty_clear);
         rx_quiet_flag <= !rx_busy;
         addr_hit <= addr_take || (addr_hit && !(wr_stat && pwdata[uart_ctl_pkg::S_ADDR_HIT]));
      end
   end

   // -------------------------------------------------------------------------
   // Wake detection
   // -------------------------------------------------------------------------
   // Pin and clock-state inputs are asynchronous, so both pass two flip-flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
         rx_prev <= 1'b1;
         fh_meta <= 1'b1;
         fh_sync <= 1'b1;
      end else begin
         rx_meta <= rx_pin;
         rx_sync <= rx_meta;
         rx_prev <= rx_sync;
         fh_meta <= fh_running;
         fh_sync <= fh_meta;
      end
   end

   wire logic wake_en = uart_control_b[uart_ctl_pkg::B_WAKE];
   wire logic rx_fall = rx_prev && !rx_sync;
   wire logic wake_event = rx_fall && wake_en && !fh_sync;

   // Sticky until software writes one to its status bit.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_request <= 1'b0;
      end else begin
         wake_request <= wake_event || (wake_request && !(wr_stat && pwdata[uart_ctl_pkg::S_WAKE]));
      end
   end

   // -------------------------------------------------------------------------
   // Interrupt request
   // -------------------------------------------------------------------------
   wire logic rx_ie = uart_control_b[uart_ctl_pkg::B_RX_IE];
   wire logic irq_rx = rx_ie && (rx_data_ready || overrun_error);
   wire logic irq_idle = uart_control_b[uart_ctl_pkg::B_IDLE_IE] && tx_idle_flag;
   wire logic irq_empty = uart_control_b[uart_ctl_pkg::B_EMPTY_IE] && tx_buffer_empty;
   wire logic irq_addr = rx_ie && addr_hit;
   wire logic irq_wake = rx_ie && wake_request;

   // Level request that follows its sources one cycle later.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uart_irq <= 1'b0;
      end else begin
         uart_irq <= irq_rx || irq_idle || irq_empty || irq_addr || irq_wake;
      end
   end

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   chk_irq_rx_path: assert property (@(posedge pclk) disable iff (!presetn)
      irq_rx |=> uart_irq) else $error("receive condition did not raise interrupt");
   chk_irq_idle_path: assert property (@(posedge pclk) disable iff (!presetn)
      irq_idle |=> uart_irq) else $error("idle condition did not raise interrupt");
   chk_irq_empty_path: assert property (@(posedge pclk) disable iff (!presetn)
      irq_empty |=> uart_irq) else $error("empty condition did not raise interrupt");
   chk_irq_no_cause: assert property (@(posedge pclk) disable iff (!presetn)
      !(irq_rx || irq_idle || irq_empty || irq_addr || irq_wake) |=> !uart_irq)
      else $error("interrupt raised without enabled cause");
   chk_addr_drop: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_word_valid && addr_det && !addr_bit) |=> !rx_word_accept)
      else $error("data word accepted during address detect");
   chk_addr_flag: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_word_valid && rx_own && addr_det && addr_bit) |=> (addr_hit || !master))
      else $error("address word did not set address flag");
   chk_wake_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      (!wake_request && (fh_sync || !wake_en)) |=> !wake_request)
      else $error("wake request while clock runs or wake disabled");
   chk_wake_edge: assert property (@(posedge pclk) disable iff (!presetn)
      ($fell(rx_sync) && wake_en && !fh_sync) |=> wake_request)
      else $error("falling receive edge did not raise wake");
   chk_disable_flags: assert property (@(posedge pclk) disable iff (!presetn)
      shut |=> (tx_idle_flag && tx_buffer_empty && rx_quiet_flag && !rx_data_ready && !overrun_error
                && !uart_control_b[uart_ctl_pkg::B_TX_ON] && !uart_control_b[uart_ctl_pkg::B_RX_ON]))
      else $error("disable left flags or enables wrong");
   chk_pins_owned: assert property (@(posedge pclk) disable iff (!presetn)
      tx_pin_oe |-> $past(master)) else $error("transmit pin driven while disabled");
   chk_idle_high: assert property (@(posedge pclk) disable iff (!presetn)
      (!tx_busy) |=> tx_pin_out) else $error("transmit pin low while idle");
   chk_baud_reset: assert property (@(posedge pclk) disable iff (!presetn)
      !master |=> !baud_tick) else $error("baud tick while disabled");
   chk_flush_on_off: assert property (@(posedge pclk) disable iff (!presetn)
      shut |=> datapath_flush [*2]) else $error("buffer not flushed on disable");

   // Idle flag, pin, break and format checks; the divisor must ride through a shutdown untouched.
   chk_idle_set: assert property (@(posedge pclk) disable iff (!presetn)
      (tx_buffer_empty && !tx_busy) |=> tx_idle_flag) else $error("idle flag not set when empty");
   chk_rx_owner: assert property (@(posedge pclk) disable iff (!presetn)
      rx_pin_owned |-> $past(master && uart_control_b[uart_ctl_pkg::B_RX_ON]))
      else $error("receive pin owned while disabled");
   chk_break_off: assert property (@(posedge pclk) disable iff (!presetn)
      !master |=> !break_send) else $error("break sent while disabled");
   chk_pin_follow: assert property (@(posedge pclk) disable iff (!presetn)
      (tx_busy && tx_own) |=> (tx_pin_out == $past(tx_serial))) else $error("transmit pin lost serial data");
   chk_divisor_kept: assert property (@(posedge pclk) disable iff (!presetn)
      shut |=> $stable(baud_divisor_reg)) else $error("divisor changed by disable");
   chk_format_copy: assert property (@(posedge pclk) disable iff (!presetn)
      nine_bit_select |-> $past(uart_control_a[uart_ctl_pkg::A_NINE_BIT]))
      else $error("frame format not taken from control");
endmodule : uart_ctl

// ===== verilog/uart_ctl_pkg.sv
// Constants shared by the serial control block and its baud rate generator.
package uart_ctl_pkg;
   // -------------------------------------------------------------------------
   // Register byte addresses
   // -------------------------------------------------------------------------
   localparam logic [7:0] ADDR_CONTROL_A = 8'h00;
   localparam logic [7:0] ADDR_CONTROL_B = 8'h04;
   localparam logic [7:0] ADDR_DIVISOR = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   // -------------------------------------------------------------------------
   // Control A fields
   // -------------------------------------------------------------------------
   localparam int A_MASTER = 7;
   localparam int A_NINE_BIT = 6;
   localparam int A_PARITY_ON = 5;
   localparam int A_PARITY_ODD = 4;
   localparam int A_TWO_STOP = 3;
   localparam int A_BREAK = 2;
   localparam int A_RX_NINTH = 1;
   localparam int A_TX_NINTH = 0;
   // -------------------------------------------------------------------------
   // Control B fields
   // -------------------------------------------------------------------------
   localparam int B_TX_ON = 7;
   localparam int B_RX_ON = 6;
   localparam int B_SPEED = 5;
   localparam int B_ADDR_DET = 4;
   localparam int B_WAKE = 3;
   localparam int B_RX_IE = 2;
   localparam int B_IDLE_IE = 1;
   localparam int B_EMPTY_IE = 0;
   // -------------------------------------------------------------------------
   // Status fields
   // -------------------------------------------------------------------------
   localparam int S_RX_READY = 0;
   localparam int S_OVERRUN = 1;
   localparam int S_FRAMING = 2;
   localparam int S_PARITY = 3;
   localparam int S_NOISE = 4;
   localparam int S_TX_IDLE = 5;
   localparam int S_TX_EMPTY = 6;
   localparam int S_RX_QUIET = 7;
   localparam int S_ADDR_HIT = 8;
   localparam int S_WAKE = 9;
   // -------------------------------------------------------------------------
   // Reset values and timing
   // -------------------------------------------------------------------------
   localparam logic [7:0] RESET_CONTROL_A = 8'h00;
   localparam logic [7:0] RESET_CONTROL_B = 8'h00;
   localparam logic [7:0] RESET_DIVISOR = 8'h00;
   localparam logic [5:0] PRESCALE_LOW_LAST = 6'h3F;
   localparam logic [5:0] PRESCALE_HIGH_LAST = 6'h0F;
endpackage : uart_ctl_pkg
